// ==== timer16_map.vh ====
// Register map, field positions, reset values and timing constants of the 16-bit timer register block
//
// Behaviour
// [RQ1] Hold a 16-bit compare-B value and compare it with the counter continuously.
// [RQ2] Compare-value writes update both bytes at once through the shared high-byte latch.
// [RQ3] On a qualified pin or comparator event, copy the counter into capture value.
// [RQ4] Capture value reads atomically; high byte comes through the shared latch.
// [RQ5] Capture value can serve as counter TOP in modes that select it.
// [RQ6] Capture interrupt requested when enable bit 5, global enable and flag are set.
// [RQ7] Compare-A interrupt requested when enable bit 4, global enable and flag are set.
// [RQ8] Compare-B interrupt requested when enable bit 3, global enable and flag are set.
// [RQ9] Overflow interrupt requested when enable bit 2, global enable and flag are set.
// [RQ10] Capture event sets the capture flag, bit 5 of the flag register.
// [RQ11] With capture value as TOP, capture flag sets when counter reaches TOP.
// [RQ12] Compare-A flag, bit 4, sets one timer clock after counter equals compare-A.
// [RQ13] Compare-B flag, bit 3, sets one timer clock after counter equals compare-B.
// [RQ14] Forced compare strobes act on the output but never set compare flags.
// [RQ15] Overflow flag, bit 2, sets at overflow per mode table.
// [RQ16] Flags clear on vector execution or when software writes a one.
// [RQ17] With capture value as TOP, the capture pin is disconnected.
// [RQ18] Edge select zero picks falling, one picks rising capture edge.
// [RQ19] Noise filter changes output only after four equal successive samples; the filter here needs five (four held plus the current one).
// [RQ20] A counter write blocks every compare match on the following timer clock.
// [RQ21] Write high byte first into latch; low write commits; low read latches high.
// [RQ22] Reserved bit 1 of mask and flag registers reads zero, ignores writes.
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH
// Word offsets on the register bus
`define OFS_CNT_LO 4'h0
`define OFS_CNT_HI 4'h1
`define OFS_CMPA_LO 4'h2
`define OFS_CMPA_HI 4'h3
`define OFS_CMPB_LO 4'h4
`define OFS_CMPB_HI 4'h5
`define OFS_CAP_LO 4'h6
`define OFS_CAP_HI 4'h7
`define OFS_MASK 4'h8
`define OFS_FLAGS 4'h9
`define OFS_CTRL 4'ha
`define OFS_ACK 4'hb
// Bit positions in mask and flag registers
`define BIT_CAP 5
`define BIT_CMPA 4
`define BIT_CMPB 3
`define BIT_OVF 2
`define IRQ_BITS_MASK 8'h3c
// Control register fields
`define CTRL_WGM_LSB 0
`define CTRL_RUN 4
`define CTRL_EDGE 5
`define CTRL_FILT 6
`define CTRL_ACSEL 7
`define CTRL_FOCA 8
`define CTRL_FOCB 9
`define CTRL_RESET 10'h000
`define MASK_RESET 8'h00
`define FLAGS_RESET 8'h00
// Noise filter history length; the current sample makes one more
`define FILTER_SAMPLES 4
`endif

// ==== capture_filter.v ====
// Capture input noise filter: output changes after a run of equal samples
`timescale 1ns/1ns
module capture_filter #(
	parameter SAMPLES = 4
) (
	// Clock and reset
	input wire clock,
	input wire reset,
	// Sampled input and control
	input wire sampleIn,
	input wire filterOn,
	// Filtered level
	output reg levelOut
);
	reg [SAMPLES-1:0] history_reg;
	wire allHigh;
	wire allLow;

	assign allHigh = &{history_reg, sampleIn};
	assign allLow = ~|{history_reg, sampleIn};

	// Shift samples; with the filter on, follow only a full run of equal values
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			history_reg <= {SAMPLES{1'b0}};
			levelOut <= 1'b0;
		end else begin
			history_reg <= {history_reg[SAMPLES-2:0], sampleIn};
			if (!filterOn)
				levelOut <= sampleIn;
			else if (allHigh) // see [RQ19]
				levelOut <= 1'b1;
			else if (allLow)
				levelOut <= 1'b0;
		end
	end
endmodule

// ==== timer16_capture_compare_irq.v ====
// 16-bit timer with capture, two compares, shared high-byte latch and interrupt flags
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "timer16_map.vh"
module timer16_capture_compare_irq #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire clock,
	input wire reset,
	// Avalon-MM slave
	input wire [3:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output reg waitrequest,
	// Timer tick and capture sources
	input wire timerTick,
	input wire capture_input_pin,
	input wire comparatorIn,
	// Interrupt controller side
	input wire globalIrqEnable,
	input wire [3:0] vectorAck,
	output reg captureIrq,
	output reg compareAIrq,
	output reg compareBIrq,
	output reg overflowIrq,
	// Match strobes towards the waveform generator
	output reg matchAOut,
	output reg matchBOut
);
	localparam [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};
	localparam [WIDTH-1:0] ZERO = {WIDTH{1'b0}};

	reg [WIDTH-1:0] counter_value_reg;
	reg countDown_reg;
	reg [WIDTH-1:0] compare_value_a_reg;
	reg [WIDTH-1:0] compare_value_b_reg;
	reg [WIDTH-1:0] capture_value_reg;
	reg [7:0] highLatch_reg;
	reg [7:0] timer_irq_enable_mask;
	reg [7:0] timer_irq_flags;
	reg [9:0] control_reg;
	reg blockMatch_reg;
	reg matchA_reg;
	reg matchB_reg;
	reg pinSync1_reg;
	reg pinSync2_reg;
	reg cmpSync1_reg;
	reg cmpSync2_reg;
	reg capLevelPrev_reg;
	reg accessDone_reg;
	wire capFiltered;
	wire [3:0] mode;
	wire captureIsTop;
	wire [WIDTH-1:0] topValue;
	wire atTop;
	wire atMax;
	wire atBottom;
	wire dualSlope;
	wire capSource;
	wire capEdge;
	wire captureEvent;
	wire busWrite;
	wire busRead;
	wire cntWrite;
	wire [7:0] setFlags;
	wire [7:0] clrFlags;
	reg overflowEvent;
	reg [WIDTH-1:0] counter_next;
	reg countDown_next;

	// Decodes a bus offset, used only by the counter write and flag clear paths
	function isOffset;
		input [3:0] addr;
		input [3:0] ofs;
		begin
			isOffset = (addr == ofs);
		end
	endfunction

	// Top value per waveform mode
	function [WIDTH-1:0] topOf;
		input [3:0] m;
		input [WIDTH-1:0] cmpA;
		input [WIDTH-1:0] cap;
		begin
			case (m)
				4'h1, 4'h5: topOf = {{(WIDTH-8){1'b0}}, 8'hff};
				4'h2, 4'h6: topOf = {{(WIDTH-9){1'b0}}, 9'h1ff};
				4'h3, 4'h7: topOf = {{(WIDTH-10){1'b0}}, 10'h3ff};
				4'h4, 4'h9, 4'hb, 4'hf: topOf = cmpA;
				4'h8, 4'ha, 4'hc, 4'he: topOf = cap;
				default: topOf = ALL_ONES;
			endcase
		end
	endfunction

	assign mode = control_reg[`CTRL_WGM_LSB+3:`CTRL_WGM_LSB];
	// Capture value as TOP in modes 8, 10, 12, 14
	assign captureIsTop = (mode == 4'h8) || (mode == 4'ha) || (mode == 4'hc) || (mode == 4'he); // see [RQ5]
	assign topValue = topOf(mode, compare_value_a_reg, capture_value_reg); // see [RQ5]
	assign dualSlope = (mode == 4'h1) || (mode == 4'h2) || (mode == 4'h3) ||
		((mode >= 4'h8) && (mode <= 4'hb));
	assign atTop = (counter_value_reg == topValue);
	assign atMax = (counter_value_reg == ALL_ONES);
	assign atBottom = (counter_value_reg == ZERO);

	// A write lands only at the edge where the master samples waitrequest low
	assign busWrite = write && accessDone_reg;
	assign busRead = read && !accessDone_reg;
	assign cntWrite = busWrite && isOffset(address, `OFS_CNT_LO);

	// Synchronise external capture sources before any logic reads them
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			pinSync1_reg <= 1'b0;
			pinSync2_reg <= 1'b0;
			cmpSync1_reg <= 1'b0;
			cmpSync2_reg <= 1'b0;
		end else begin
			pinSync1_reg <= capture_input_pin;
			pinSync2_reg <= pinSync1_reg;
			cmpSync1_reg <= comparatorIn;
			cmpSync2_reg <= cmpSync1_reg;
		end
	end

	assign capSource = control_reg[`CTRL_ACSEL] ? cmpSync2_reg : pinSync2_reg;

	capture_filter #(
		.SAMPLES(`FILTER_SAMPLES)
	) filterInst (
		.clock(clock),
		.reset(reset),
		.sampleIn(capSource),
		.filterOn(control_reg[`CTRL_FILT]),
		.levelOut(capFiltered)
	);

	// Edge select: one rising, zero falling; pin is disconnected when capture is TOP
	assign capEdge = control_reg[`CTRL_EDGE] ? (capFiltered && !capLevelPrev_reg)
		: (!capFiltered && capLevelPrev_reg); // see [RQ18]
	assign captureEvent = capEdge && !captureIsTop; // see [RQ17]

	// Counter sequencing: CPU write has priority over counting
	always @* begin
		counter_next = counter_value_reg;
		countDown_next = countDown_reg;
		overflowEvent = 1'b0;
		if (timerTick && control_reg[`CTRL_RUN]) begin
			if (dualSlope) begin
				if (countDown_reg) begin
					if (atBottom) begin
						countDown_next = 1'b0;
						counter_next = counter_value_reg + 1'b1;
					end else begin
						counter_next = counter_value_reg - 1'b1;
					end
				end else if (atTop) begin
					countDown_next = 1'b1;
					counter_next = counter_value_reg - 1'b1;
				end else begin
					counter_next = counter_value_reg + 1'b1;
				end
				overflowEvent = countDown_reg && atBottom;
			end else if (atTop && (mode != 4'h0)) begin
				counter_next = ZERO;
				// Fast PWM flags at TOP, clear-on-match flags at MAX
				overflowEvent = (mode == 4'h4 || mode == 4'hc) ? atMax : 1'b1;
			end else begin
				counter_next = counter_value_reg + 1'b1;
				overflowEvent = atMax; // see [RQ15]
			end
		end
		if (cntWrite) begin
			counter_next = {highLatch_reg, writedata[7:0]}; // see [RQ21]
			countDown_next = 1'b0;
		end
	end

	// Compare stage: a match is registered and flagged one timer clock later
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			counter_value_reg <= ZERO;
			countDown_reg <= 1'b0;
			blockMatch_reg <= 1'b0;
			matchA_reg <= 1'b0;
			matchB_reg <= 1'b0;
			capLevelPrev_reg <= 1'b0;
		end else begin
			counter_value_reg <= counter_next;
			countDown_reg <= countDown_next;
			capLevelPrev_reg <= capFiltered;
			// A counter write holds off matches until the next timer clock has passed
			if (cntWrite)
				blockMatch_reg <= 1'b1; // see [RQ20]
			else if (timerTick)
				blockMatch_reg <= 1'b0;
			matchA_reg <= timerTick && !blockMatch_reg && !cntWrite &&
				(counter_value_reg == compare_value_a_reg); // see [RQ12]
			matchB_reg <= timerTick && !blockMatch_reg && !cntWrite &&
				(counter_value_reg == compare_value_b_reg); // see [RQ1] [RQ13]
		end
	end

	// Flag set and clear; a set arriving with a clear wins
	assign setFlags[`BIT_CAP] = captureEvent || (captureIsTop && timerTick && control_reg[`CTRL_RUN] &&
		atTop); // see [RQ10] [RQ11]
	assign setFlags[`BIT_CMPA] = matchA_reg; // see [RQ14]
	assign setFlags[`BIT_CMPB] = matchB_reg; // see [RQ14]
	assign setFlags[`BIT_OVF] = overflowEvent;
	assign setFlags[7:6] = 2'b00;
	assign setFlags[1:0] = 2'b00;
	assign clrFlags = (busWrite && isOffset(address, `OFS_FLAGS) ? writedata[7:0] : 8'h00) |
		{2'b00, vectorAck, 2'b00}; // see [RQ16]

	// Register writes, capture loading and the shared high-byte latch
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			compare_value_a_reg <= ZERO;
			compare_value_b_reg <= ZERO;
			capture_value_reg <= ZERO;
			highLatch_reg <= 8'h00;
			timer_irq_enable_mask <= `MASK_RESET;
			timer_irq_flags <= `FLAGS_RESET;
			control_reg <= `CTRL_RESET;
		end else begin
			timer_irq_flags <= ((timer_irq_flags & ~clrFlags) | setFlags) & `IRQ_BITS_MASK; // see [RQ22]
			if (captureEvent)
				capture_value_reg <= counter_value_reg; // see [RQ3]
			// Force strobes are self-clearing and stay stored for one cycle only
			control_reg[`CTRL_FOCB:`CTRL_FOCA] <= 2'b00;
			if (busWrite) begin
				case (address)
					`OFS_CNT_HI, `OFS_CMPA_HI, `OFS_CMPB_HI, `OFS_CAP_HI:
						highLatch_reg <= writedata[7:0]; // see [RQ2] [RQ21]
					`OFS_CMPA_LO:
						compare_value_a_reg <= {highLatch_reg, writedata[7:0]};
					`OFS_CMPB_LO:
						compare_value_b_reg <= {highLatch_reg, writedata[7:0]}; // see [RQ2]
					`OFS_CAP_LO:
						if (!captureEvent)
							capture_value_reg <= {highLatch_reg, writedata[7:0]};
					`OFS_MASK:
						timer_irq_enable_mask <= writedata[7:0] & `IRQ_BITS_MASK; // see [RQ22]
					`OFS_CTRL:
						control_reg <= writedata[9:0];
					default: begin
					end
				endcase
			end else if (busRead) begin
				// Low-byte read freezes the high byte for the following high-byte read
				case (address)
					`OFS_CNT_LO: highLatch_reg <= counter_value_reg[15:8];
					`OFS_CMPA_LO: highLatch_reg <= compare_value_a_reg[15:8];
					`OFS_CMPB_LO: highLatch_reg <= compare_value_b_reg[15:8];
					`OFS_CAP_LO: highLatch_reg <= capture_value_reg[15:8]; // see [RQ4]
					default: begin
					end
				endcase
			end
		end
	end

	// Bus answer: waitrequest high until the access edge, then one cycle low
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			accessDone_reg <= 1'b0;
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
		end else begin
			accessDone_reg <= (read || write) && !accessDone_reg;
			waitrequest <= !((read || write) && !accessDone_reg);
			if (busRead) begin
				case (address)
					`OFS_CNT_LO: readdata <= {24'h000000, counter_value_reg[7:0]};
					`OFS_CMPA_LO: readdata <= {24'h000000, compare_value_a_reg[7:0]};
					`OFS_CMPB_LO: readdata <= {24'h000000, compare_value_b_reg[7:0]};
					`OFS_CAP_LO: readdata <= {24'h000000, capture_value_reg[7:0]};
					`OFS_CNT_HI, `OFS_CMPA_HI, `OFS_CMPB_HI, `OFS_CAP_HI:
						readdata <= {24'h000000, highLatch_reg}; // see [RQ4]
					`OFS_MASK: readdata <= {24'h000000, timer_irq_enable_mask};
					`OFS_FLAGS: readdata <= {24'h000000, timer_irq_flags};
					`OFS_CTRL: readdata <= {22'h000000, 2'b00, control_reg[7:0]};
					default: readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Interrupt requests and match strobes, all registered
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			captureIrq <= 1'b0;
			compareAIrq <= 1'b0;
			compareBIrq <= 1'b0;
			overflowIrq <= 1'b0;
			matchAOut <= 1'b0;
			matchBOut <= 1'b0;
		end else begin
			captureIrq <= globalIrqEnable && timer_irq_enable_mask[`BIT_CAP] && timer_irq_flags[`BIT_CAP]; // see [RQ6]
			compareAIrq <= globalIrqEnable && timer_irq_enable_mask[`BIT_CMPA] &&
				timer_irq_flags[`BIT_CMPA]; // see [RQ7]
			compareBIrq <= globalIrqEnable && timer_irq_enable_mask[`BIT_CMPB] &&
				timer_irq_flags[`BIT_CMPB]; // see [RQ8]
			overflowIrq <= globalIrqEnable && timer_irq_enable_mask[`BIT_OVF] && timer_irq_flags[`BIT_OVF]; // see [RQ9]
			// Forced strobes drive the waveform side like a match but bypass the flags
			matchAOut <= matchA_reg || control_reg[`CTRL_FOCA]; // see [RQ14]
			matchBOut <= matchB_reg || control_reg[`CTRL_FOCB]; // see [RQ14]
		end
	end
endmodule

// ==== timer16_checker.sv ====
// Concurrent checks on the ports of the 16-bit timer register block
`timescale 1ns/1ns
`include "timer16_map.vh"
module timer16_checker (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Register bus
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic waitrequest,
	// Interrupt side
	input wire logic globalIrqEnable,
	input wire logic [3:0] vectorAck,
	input wire logic captureIrq,
	input wire logic compareAIrq,
	input wire logic compareBIrq,
	input wire logic overflowIrq,
	// Match strobes
	input wire logic matchAOut,
	input wire logic matchBOut
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	// Bus accept lasts one cycle and comes one cycle after the request is seen
	a_accept_one_cycle: assert property ($fell(waitrequest) |=> waitrequest)
		else $error("accept held longer than one cycle");
	a_request_answered: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
		else $error("request not accepted in time");
	a_idle_no_accept: assert property (!read && !write && waitrequest |=> waitrequest)
		else $error("accept without a request");

	// Requests need the global enable; a rising capture request had it a cycle before
	a_irq_global_gate: assert property (!globalIrqEnable |=> !(captureIrq || compareAIrq || compareBIrq || overflowIrq))
		else $error("interrupt request while globally disabled");
	a_capture_irq_rise: assert property ($rose(captureIrq) |-> $past(globalIrqEnable))
		else $error("capture request rose without global enable");

	// Executing a vector clears its flag, so the request drops two cycles later
	a_ack_clears_cap: assert property (vectorAck[3] |-> ##2 !captureIrq)
		else $error("capture request survives its vector");
	a_ack_clears_cmpa: assert property (vectorAck[2] |-> ##2 !compareAIrq)
		else $error("compare A request survives its vector");

	// A force strobe still acts on the output as a match would
	a_force_a_strobe: assert property (write && !waitrequest && address == `OFS_CTRL && writedata[`CTRL_FOCA]
		|-> ##[1:3] matchAOut)
		else $error("force A gave no match strobe");
	a_force_b_strobe: assert property (write && !waitrequest && address == `OFS_CTRL && writedata[`CTRL_FOCB]
		|-> ##[1:3] matchBOut)
		else $error("force B gave no match strobe");
endmodule

bind timer16_capture_compare_irq timer16_checker chk_i (.clock(clock), .reset(reset), .address(address),
	.read(read), .write(write), .writedata(writedata), .waitrequest(waitrequest),
	.globalIrqEnable(globalIrqEnable), .vectorAck(vectorAck), .captureIrq(captureIrq),
	.compareAIrq(compareAIrq), .compareBIrq(compareBIrq), .overflowIrq(overflowIrq),
	.matchAOut(matchAOut), .matchBOut(matchBOut));

// ==== cpu_vector_model.sv ====
// CPU model that executes the interrupt vector of a pending request
`timescale 1ns/1ns
module cpu_vector_model (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Requests and servicing switch
	input wire logic [3:0] irqLines,
	input wire logic ackEnable,
	// Vector executed strobes
	output logic [3:0] vectorAck
);
	logic [1:0] holdCnt_reg;

	// One vector at a time, lowest first; wait out the request's lag before the next
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			vectorAck <= 4'h0;
			holdCnt_reg <= 2'h0;
		end else if (holdCnt_reg != 2'h0) begin
			vectorAck <= 4'h0;
			holdCnt_reg <= holdCnt_reg - 2'h1;
		end else if (ackEnable && irqLines != 4'h0) begin
			vectorAck <= irqLines & (~irqLines + 4'h1);
			holdCnt_reg <= 2'h3;
		end
	end
endmodule

// ==== tb.sv ====
// Self-checking testbench for the 16-bit timer register block
`timescale 1ns/1ns
`include "timer16_map.vh"
module tb;
	logic clock, reset, read, write, timerTick, capPin, comparatorIn, globalIrqEnable, ackOn;
	logic [3:0] address;
	logic [31:0] writedata;
	wire [31:0] readdata;
	wire waitrequest, captureIrq, compareAIrq, compareBIrq, overflowIrq, matchAOut, matchBOut;
	wire [3:0] vectorAck;
	wire [3:0] irqs = {captureIrq, compareAIrq, compareBIrq, overflowIrq};
	int nMismatch = 0;
	int checkCount = 0;

	timer16_capture_compare_irq uut (.clock(clock), .reset(reset), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.timerTick(timerTick), .capture_input_pin(capPin), .comparatorIn(comparatorIn),
		.globalIrqEnable(globalIrqEnable), .vectorAck(vectorAck), .captureIrq(captureIrq),
		.compareAIrq(compareAIrq), .compareBIrq(compareBIrq), .overflowIrq(overflowIrq),
		.matchAOut(matchAOut), .matchBOut(matchBOut));
	cpu_vector_model cpu (.clock(clock), .reset(reset), .irqLines(irqs), .ackEnable(ackOn), .vectorAck(vectorAck));

	// 20 MHz clock
	always #25 clock = ~clock;

	task print_verdict;
		begin
			if (nMismatch == 0 && checkCount > 0) begin
				$display("Finished cleanly");
			end else begin
				$display("Finished with errors");
			end
			$finish;
		end
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			checkCount++;
			if (got !== exp) begin
				$display("BAD %0t got %h expected %h", $time, got, exp);
				nMismatch++;
			end
		end
	endtask

	// One bus transfer; held until waitrequest is sampled low, since the slave sets the pace
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		begin
			@(posedge clock);
			read <= !w;
			write <= w;
			address <= a;
			writedata <= d;
			@(posedge clock);
			while (waitrequest !== 1'b0) @(posedge clock);
			q = readdata;
			read <= 1'b0;
			write <= 1'b0;
		end
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		begin
			bus(1'b1, a, d, q);
		end
	endtask

	task rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		begin
			bus(1'b0, a, 32'h0, q);
			chk(q, e);
		end
	endtask

	// High byte goes to the shared latch first; the low write commits both
	task wr16(input logic [3:0] lo, input logic [15:0] v);
		begin
			wr(lo + 4'h1, {24'h0, v[15:8]});
			wr(lo, {24'h0, v[7:0]});
		end
	endtask

	task rd16(input logic [3:0] lo, input logic [15:0] e);
		begin
			rd(lo, {24'h0, e[7:0]});
			rd(lo + 4'h1, {24'h0, e[15:8]});
		end
	endtask

	task idle(input int n);
		repeat (n) @(posedge clock);
	endtask

	task tick(input int n);
		repeat (n) begin
			@(posedge clock);
			timerTick <= 1'b1;
			@(posedge clock);
			timerTick <= 1'b0;
		end
	endtask

	// Watchdog: the sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clock);
		nMismatch++;
		print_verdict;
	end

	initial begin
		clock = 1'b0;
		reset = 1'b1;
		{read, write, timerTick, capPin, comparatorIn, globalIrqEnable, ackOn} = 7'h00;
		address = 4'h0;
		writedata = 32'h0;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		rd(`OFS_MASK, 32'h0);
		rd(`OFS_FLAGS, 32'h0);
		wr(4'hc, 32'hff);
		rd(4'hc, 32'h0);
		wr(`OFS_MASK, 32'hff);
		rd(`OFS_MASK, 32'h3c);
		wr(`OFS_MASK, 32'h0);
		wr16(`OFS_CMPB_LO, 16'ha55a);
		rd16(`OFS_CMPB_LO, 16'ha55a);
		wr(`OFS_CMPB_HI, 32'h77);
		rd16(`OFS_CMPB_LO, 16'ha55a);
		// Counter loaded onto a compare value: the first tick must not match
		wr16(`OFS_CMPA_LO, 16'h0002);
		wr16(`OFS_CMPB_LO, 16'h0004);
		wr16(`OFS_CNT_LO, 16'h0002);
		wr(`OFS_CTRL, 32'h10);
		tick(1);
		rd(`OFS_FLAGS, 32'h0);
		tick(3);
		rd(`OFS_FLAGS, 32'h08);
		wr16(`OFS_CNT_LO, 16'h0000);
		tick(3);
		rd(`OFS_FLAGS, 32'h18);
		wr16(`OFS_CNT_LO, 16'hffff);
		tick(2);
		rd(`OFS_FLAGS, 32'h1c);
		wr(`OFS_FLAGS, 32'h04);
		rd(`OFS_FLAGS, 32'h18);
		// Stopped counter, falling edge selected: a rising pin must not capture
		wr(`OFS_CTRL, 32'h0);
		wr16(`OFS_CNT_LO, 16'h1234);
		capPin <= 1'b1;
		idle(12);
		rd(`OFS_FLAGS, 32'h18);
		capPin <= 1'b0;
		idle(12);
		rd(`OFS_FLAGS, 32'h38);
		rd16(`OFS_CAP_LO, 16'h1234);
		globalIrqEnable <= 1'b1;
		idle(3);
		chk({28'h0, irqs}, 32'h0);
		wr(`OFS_MASK, 32'h3c);
		idle(3);
		chk({28'h0, irqs}, 32'he);
		globalIrqEnable <= 1'b0;
		idle(3);
		chk({28'h0, irqs}, 32'h0);
		globalIrqEnable <= 1'b1;
		ackOn <= 1'b1;
		idle(30);
		rd(`OFS_FLAGS, 32'h0);
		chk({28'h0, irqs}, 32'h0);
		ackOn <= 1'b0;
		wr(`OFS_CTRL, 32'h300);
		idle(4);
		rd(`OFS_FLAGS, 32'h0);
		// Filter on, rising edge: a two-cycle glitch is ignored, a steady high captures
		wr(`OFS_CTRL, 32'h60);
		capPin <= 1'b1;
		idle(2);
		capPin <= 1'b0;
		idle(12);
		rd(`OFS_FLAGS, 32'h0);
		capPin <= 1'b1;
		idle(12);
		rd(`OFS_FLAGS, 32'h20);
		wr(`OFS_FLAGS, 32'h20);
		// Capture value as TOP: the pin is disconnected
		wr(`OFS_CTRL, 32'h08);
		capPin <= 1'b0;
		idle(12);
		rd(`OFS_FLAGS, 32'h0);
		print_verdict;
	end
endmodule
